//--- dv/serial_peer_model.sv
/*
  Far station on the serial link: sends one 11-bit frame on request.
  Assumes the bench clock and a fixed bit time in clock cycles.
*/
// ****
// Peer
// ****
module serial_peer_model #(
  parameter int BIT_CLKS = 64
) (
  input wire logic aclk,
  input wire logic send,
  input wire logic [8:0] word,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] frame;
  // The line idles high between frames, as an async link does.
  initial line = 1'b1;
  always @(posedge aclk) begin
    if (send) begin
      frame = {1'b1, word, 1'b0};
      for (int i = 0; i < 11; i++) begin
        line <= frame[i];
        repeat (BIT_CLKS) @(posedge aclk);
      end
    end
  end
endmodule

//--- dv/serial_port_addr_match_tb_top.sv
/*
  Bench of the serial port: register rows, transmit and receive tables, FIFO flood.
  Assumes the design files and the consts header on the include path.
*/
`include "serial_port_consts.svh"
// ****
// Bench
// ****
module serial_port_addr_match_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [11:0] a; logic [7:0] d; logic [1:0] resp;} row_t;
  typedef struct packed {logic [7:0] ctl; logic [7:0] pwr; logic [7:0] clks; logic [7:0] d;} tx_t;
  typedef struct packed {logic [7:0] ctl; logic [7:0] mask; logic [8:0] w; logic done;} rx_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, baud_tick, peer_send, rxd_line;
  logic awready, wready, bvalid, arready, rvalid, rxd_out, rxd_oe, txd_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp, tick_cnt;
  logic [8:0] peer_word;
  logic [10:0] ex;
  int n_errors = 0;
  int n_compared = 0;
  int n, c;
  row_t rows [6] = '{'{1, `ADDR_MASK, 8'ha5, 0}, '{0, `ADDR_MASK, 8'ha5, 0}, '{1, `ADDR_STATION, 8'h3c, 0},
    '{0, `ADDR_STATION, 8'h3c, 0}, '{1, 12'h010, 8'h77, 2}, '{0, 12'h010, 8'h00, 2}};
  tx_t txs [4] = '{'{8'h88, 8'h00, 64, 8'ha6}, '{8'h80, 8'h02, 32, 8'h59}, '{8'hc8, 8'h00, 64, 8'h3c},
    '{8'h40, 8'h00, 64, 8'hc3}};
  // In mode 1 the peer's ninth word bit lands on the stop bit, so the first row sends a bad stop.
  rx_t rxs [7] = '{'{8'h70, 8'h00, 9'h055, 0}, '{8'h50, 8'h00, 9'h1a5, 1},
    '{8'ha0, 8'h00, 9'h133, 0}, '{8'hb0, 8'h00, 9'h033, 0}, '{8'hb0, 8'hff, 9'h133, 0},
    '{8'hb0, 8'hf0, 9'h13a, 1}, '{8'hb0, 8'h00, 9'h1c5, 1}};
  serial_port_addr_match uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .baud_tick(baud_tick),
    .rxd_in(rxd_oe ? rxd_out : rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
  serial_peer_model #(.BIT_CLKS(64)) peer (.aclk(aclk), .send(peer_send), .word(peer_word), .line(rxd_line));
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  // One tick every four clocks gives 64 clocks per bit in modes 1 and 3.
  always @(posedge aclk) begin
    tick_cnt <= tick_cnt + 1;
    baud_tick <= (tick_cnt == 3);
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic fail();
    $display("[ERR] %0t wait ran out", $time);
    n_errors++;
    conclude();
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 4000);
    resp = bresp;
    if (n >= 4000) fail();
  endtask
  task automatic rdr(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 4000);
    rd = rdata;
    resp = rresp;
    if (n >= 4000) fail();
  endtask
  task automatic wait_low();
    n = 0;
    while (txd_out !== 1'b0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 2000) fail();
  endtask
  initial begin
    {aresetn, awvalid, wvalid, arvalid, peer_send, tick_cnt, baud_tick} = 0;
    {bready, rready, wstrb, awaddr, araddr, wdata, peer_word} = {2'b11, 4'hf, 65'h0};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      else rdr(rows[i].a);
      if (!rows[i].wr) chk(rd, {24'h00_0000, rows[i].d});
      chk(32'(resp), 32'(rows[i].resp));
    end
    rdr(`ADDR_CTRL);
    chk(rd, 32'h0000_0000);
    foreach (txs[i]) begin
      wr(`ADDR_POWER, txs[i].pwr);
      wr(`ADDR_CTRL, txs[i].ctl);
      wr(`ADDR_DATA, txs[i].d);
      ex = {1'b1, txs[i].ctl[7] ? txs[i].ctl[3] : 1'b1, txs[i].d, 1'b0};
      wait_low();
      repeat (txs[i].clks / 2) @(posedge aclk);
      for (int b = 0; b < 11; b++) begin
        chk(32'(txd_out), 32'(ex[b]));
        repeat (txs[i].clks) @(posedge aclk);
      end
      rdr(`ADDR_CTRL);
      chk(32'(rd[1]), 1);
    end
    for (int m = 0; m < 2; m++) begin
      wr(`ADDR_CTRL, m ? 8'h20 : 8'h00);
      wr(`ADDR_DATA, 8'h81);
      wait_low();
      c = 0;
      while (txd_out === 1'b0 && c < 20) begin
        @(posedge aclk);
        c++;
      end
      chk(c, m ? 2 : 6);
      chk(32'({rxd_oe, rxd_out}), 3);
      repeat (200) @(posedge aclk);
    end
    // Mode 0 reception clocks in the idle-high line, so eight ones arrive.
    wr(`ADDR_CTRL, 8'h30);
    repeat (100) @(posedge aclk);
    rdr(`ADDR_CTRL);
    chk(32'(rd[0]), 1);
    rdr(`ADDR_DATA);
    chk(rd, 32'h0000_00ff);
    foreach (rxs[i]) begin
      wr(`ADDR_MASK, rxs[i].mask);
      wr(`ADDR_CTRL, rxs[i].ctl);
      peer_word <= rxs[i].w;
      peer_send <= 1'b1;
      @(posedge aclk);
      peer_send <= 1'b0;
      repeat (800) @(posedge aclk);
      rdr(`ADDR_CTRL);
      chk(32'(rd[0]), 32'(rxs[i].done));
    end
    chk(32'(rd[2]), 1);
    rdr(`ADDR_DATA);
    chk(rd, 32'h0000_00c5);
    // The bad stop bit of the first mode 1 row left the frame error flag set.
    wr(`ADDR_POWER, 8'h01);
    rdr(`ADDR_CTRL);
    chk(32'(rd[7]), 1);
    wr(`ADDR_CTRL, 8'h00);
    rdr(`ADDR_CTRL);
    chk(32'(rd[7]), 0);
    // Ten writes overrun the eight-word queue and the word already in the shifter, so the tenth stalls until a word drains.
    wr(`ADDR_POWER, 8'h02);
    wr(`ADDR_CTRL, 8'h80);
    for (int k = 0; k < 10; k++) begin
      wr(`ADDR_DATA, 8'(k));
      chk(32'(resp), 0);
    end
    repeat (4000) @(posedge aclk);
    // A reset in mid-frame must release the line and leave every bus channel idle.
    wr(`ADDR_DATA, 8'h5a);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({awready, wready, arready, bvalid, rvalid, txd_out, rxd_oe}), 32'h0000_0072);
    rdr(`ADDR_CTRL);
    chk(rd, 32'h0000_0000);
    conclude();
  end
endmodule

//--- hdl/serial_port_addr_match.sv
/*
  Second serial port with multiprocessor framing and slave address recognition,
  reached over AXI4-Lite, with an 8-word FIFO in front of the transmitter.
  Assumes one 100 MHz clock, a synchronous active-low reset, inputs synchronous
  to the clock and a one-cycle baud_tick at sixteen times the bit rate.
*/
`include "serial_port_consts.svh"

// ****************************************
// Transmit FIFO
// ****************************************
module serial_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_t;
  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic push;
  logic pop;

  assign in_ready = (st_reg.count != (AW + 1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rd_ptr];

  always_comb begin
    st_next = st_reg;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ****************************************
// Serial port top
// ****************************************
module serial_port_addr_match
  import serial_port_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic baud_tick,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out
);
  port_state_t st_reg;
  port_state_t st_next;
  logic [1:0] mode;
  logic [3:0] pre_max;
  logic tick_pre;
  logic async_tick;
  logic half_tick;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic wr_go;
  logic wr_mapped;
  logic stop_eval;
  logic addr_match;
  logic rx_ok;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic [3:0] tx_last;

  assign awready = st_reg.awready;
  assign wready = st_reg.wready;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = st_reg.arready;
  assign rvalid = st_reg.rvalid;
  assign rresp = st_reg.rresp;
  assign rdata = {24'h00_0000, st_reg.rdata};
  assign rxd_out = st_reg.rxd_out;
  assign rxd_oe = st_reg.rxd_oe;
  assign txd_out = st_reg.txd;

  serial_fifo #(
    .WIDTH(`DATA_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.w_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_comb begin
    st_next = st_reg;
    mode = {st_reg.mode_low, st_reg.mode_high_bit};
    // One shared prescaler: mode 2 oversample ticks or mode 0 half bit ticks.
    if (mode == 2'b10) begin
      pre_max = st_reg.double_rate ? 4'(`M2_CLK_FAST / `OVERSAMPLE - 1) : 4'(`M2_CLK_SLOW / `OVERSAMPLE - 1);
    end else begin
      pre_max = st_reg.multiproc_enable ? 4'(`M0_CLK_FAST / 2 - 1) : 4'(`M0_CLK_SLOW / 2 - 1);
    end
    tick_pre = (st_reg.pre_cnt >= pre_max);
    st_next.pre_cnt = tick_pre ? 4'h0 : st_reg.pre_cnt + 4'h1;
    async_tick = (mode == 2'b10) ? tick_pre : baud_tick;
    half_tick = (mode == 2'b00) && tick_pre;

    // ****************************************
    // Register writes
    // ****************************************
    if (awvalid && st_reg.awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = awaddr;
      st_next.awready = 1'b0;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = wdata[7:0];
      st_next.w_en = wstrb[0];
      st_next.wready = 1'b0;
    end
    wr_mapped = (st_reg.aw_addr == `ADDR_STATION) || (st_reg.aw_addr == `ADDR_MASK) ||
      (st_reg.aw_addr == `ADDR_CTRL) || (st_reg.aw_addr == `ADDR_DATA) || (st_reg.aw_addr == `ADDR_POWER);
    fifo_in_valid = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid && st_reg.w_en &&
      (st_reg.aw_addr == `ADDR_DATA);
    // A data write is held off while the FIFO is full, which stalls the bus.
    wr_go = st_reg.aw_held && st_reg.w_held && !st_reg.bvalid && (!fifo_in_valid || fifo_in_ready);
    if (wr_go) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      if (st_reg.w_en) begin
        unique case (st_reg.aw_addr)
          `ADDR_STATION: st_next.station_address = st_reg.w_data;
          `ADDR_MASK: st_next.address_compare_mask = st_reg.w_data;
          `ADDR_POWER: begin
            st_next.frame_error_select = st_reg.w_data[`PWR_FE_SELECT];
            st_next.double_rate = st_reg.w_data[`PWR_DOUBLE_RATE];
          end
          `ADDR_CTRL: begin
            if (st_reg.frame_error_select) begin
              st_next.frame_error = st_reg.w_data[`CTL_MODE_LOW];
            end else begin
              st_next.mode_low = st_reg.w_data[`CTL_MODE_LOW];
            end
            st_next.mode_high_bit = st_reg.w_data[`CTL_MODE_HIGH];
            st_next.multiproc_enable = st_reg.w_data[`CTL_MULTIPROC];
            st_next.rx_enable = st_reg.w_data[`CTL_RX_ENABLE];
            st_next.tx_ninth_bit = st_reg.w_data[`CTL_TX_NINTH];
            st_next.rx_ninth_bit = st_reg.w_data[`CTL_RX_NINTH];
            st_next.tx_done_flag = st_reg.w_data[`CTL_TX_DONE];
            st_next.rx_done_flag = st_reg.w_data[`CTL_RX_DONE];
          end
          default: ;
        endcase
      end
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // ****************************************
    // Register reads
    // ****************************************
    if (arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp = `RESP_OKAY;
      unique case (araddr)
        `ADDR_STATION: st_next.rdata = st_reg.station_address;
        `ADDR_MASK: st_next.rdata = st_reg.address_compare_mask;
        `ADDR_POWER: st_next.rdata = {6'b00_0000, st_reg.double_rate, st_reg.frame_error_select};
        `ADDR_CTRL: st_next.rdata = {st_reg.frame_error_select ? st_reg.frame_error : st_reg.mode_low,
          st_reg.mode_high_bit, st_reg.multiproc_enable, st_reg.rx_enable, st_reg.tx_ninth_bit,
          st_reg.rx_ninth_bit, st_reg.tx_done_flag, st_reg.rx_done_flag};
        `ADDR_DATA: st_next.rdata = st_reg.rx_buf;
        default: begin
          st_next.rdata = 8'h00;
          st_next.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end

    // ****************************************
    // Transmitter, after software so that hardware sets win
    // ****************************************
    tx_last = (mode == 2'b01) ? 4'd9 : 4'd10;
    fifo_out_ready = (st_reg.tx_state == TX_IDLE) && !(mode == 2'b00 && st_reg.rx_state != RX_IDLE);
    unique case (st_reg.tx_state)
      TX_IDLE: begin
        if (fifo_out_valid && fifo_out_ready) begin
          st_next.tx_state = TX_SHIFT;
          st_next.tx_bits = 4'h0;
          st_next.tx_os = 4'h0;
          if (mode == 2'b00) begin
            st_next.tx_shift = {3'b111, fifo_out_data};
            st_next.rxd_oe = 1'b1;
            st_next.rxd_out = fifo_out_data[0];
          end else begin
            st_next.tx_shift = {1'b1, (mode == 2'b01) ? 1'b1 : st_reg.tx_ninth_bit, fifo_out_data, 1'b0};
            st_next.txd = 1'b0;
          end
        end
      end
      TX_SHIFT: begin
        if (mode == 2'b00) begin
          if (half_tick && !st_reg.tx_os[0]) begin
            st_next.txd = 1'b0;
            st_next.rxd_out = st_reg.tx_shift[0];
            st_next.tx_os = 4'h1;
          end else if (half_tick) begin
            st_next.txd = 1'b1;
            st_next.tx_shift = {1'b1, st_reg.tx_shift[10:1]};
            st_next.tx_bits = st_reg.tx_bits + 4'h1;
            st_next.tx_os = 4'h0;
            if (st_reg.tx_bits == 4'h7) begin
              st_next.tx_done_flag = 1'b1;
              st_next.tx_state = TX_IDLE;
              st_next.rxd_oe = 1'b0;
            end
          end
        end else if (async_tick) begin
          st_next.tx_os = st_reg.tx_os + 4'h1;
          if (st_reg.tx_os == 4'hf) begin
            st_next.tx_shift = {1'b1, st_reg.tx_shift[10:1]};
            st_next.txd = st_reg.tx_shift[1];
            st_next.tx_bits = st_reg.tx_bits + 4'h1;
            if (st_reg.tx_bits + 4'h1 == tx_last) begin
              st_next.tx_done_flag = 1'b1;
            end
            if (st_reg.tx_bits == tx_last) begin
              st_next.tx_state = TX_IDLE;
              st_next.txd = 1'b1;
            end
          end
        end
      end
      default: st_next.tx_state = TX_IDLE;
    endcase

    // ****************************************
    // Receiver
    // ****************************************
    stop_eval = 1'b0;
    unique case (st_reg.rx_state)
      RX_IDLE: begin
        st_next.rx_os = 4'h0;
        st_next.rx_bits = 4'h0;
        if (mode == 2'b00) begin
          if (st_reg.rx_enable && !st_reg.rx_done_flag && st_reg.tx_state == TX_IDLE && !fifo_out_valid) begin
            st_next.rx_state = RX_DATA;
          end
        end else if (st_reg.rx_enable && async_tick && !rxd_in) begin
          st_next.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (async_tick) begin
          st_next.rx_os = st_reg.rx_os + 4'h1;
          if (st_reg.rx_os == 4'h7) begin
            st_next.rx_os = 4'h0;
            // A start bit that is high again at mid bit was a glitch.
            st_next.rx_state = rxd_in ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (mode == 2'b00) begin
          if (half_tick && !st_reg.rx_os[0]) begin
            st_next.txd = 1'b0;
            st_next.rx_os = 4'h1;
          end else if (half_tick) begin
            st_next.txd = 1'b1;
            st_next.rx_os = 4'h0;
            st_next.rx_shift = {rxd_in, st_reg.rx_shift[8:1]};
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
            if (st_reg.rx_bits == 4'h7) begin
              st_next.rx_buf = {rxd_in, st_reg.rx_shift[8:2]};
              st_next.rx_done_flag = 1'b1;
              st_next.rx_state = RX_IDLE;
            end
          end
        end else if (async_tick) begin
          st_next.rx_os = st_reg.rx_os + 4'h1;
          if (st_reg.rx_os == 4'hf) begin
            st_next.rx_shift = {rxd_in, st_reg.rx_shift[8:1]};
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
            if (st_reg.rx_bits == ((mode == 2'b01) ? 4'h7 : 4'h8)) begin
              st_next.rx_state = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (async_tick) begin
          st_next.rx_os = st_reg.rx_os + 4'h1;
          if (st_reg.rx_os == 4'hf) begin
            stop_eval = 1'b1;
            st_next.rx_state = RX_IDLE;
          end
        end
      end
      default: st_next.rx_state = RX_IDLE;
    endcase
    rx_data = (mode == 2'b01) ? st_reg.rx_shift[8:1] : st_reg.rx_shift[7:0];
    rx_ninth = (mode == 2'b01) ? rxd_in : st_reg.rx_shift[8];
    addr_match = (((rx_data ^ st_reg.station_address) & st_reg.address_compare_mask) == 8'h00);
    if (mode == 2'b01) begin
      rx_ok = !st_reg.rx_done_flag && (!st_reg.multiproc_enable || rxd_in);
    end else begin
      rx_ok = !st_reg.rx_done_flag && (!st_reg.multiproc_enable || (rx_ninth && addr_match));
    end
    if (stop_eval && rx_ok) begin
      st_next.rx_buf = rx_data;
      st_next.rx_ninth_bit = rx_ninth;
      st_next.rx_done_flag = 1'b1;
    end
    if (stop_eval && !rxd_in) begin
      st_next.frame_error = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
      st_reg.txd <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_gap1;
    (!tick_pre ##1 tick_pre) or ##[0:1] !(mode == 2'b10 && st_reg.double_rate);
  endsequence
  sequence s_gap3;
    (!tick_pre [*3] ##1 tick_pre) or ##[0:3] !(mode == 2'b10 && !st_reg.double_rate);
  endsequence
  sequence s_gap5;
    (!tick_pre [*5] ##1 tick_pre) or ##[0:5] !(mode == 2'b00 && !st_reg.multiproc_enable);
  endsequence

  a_mode2_slow: assert property ((mode == 2'b10 && !st_reg.double_rate && tick_pre) |=> s_gap3)
    else $error("mode 2 slow rate tick spacing wrong");
  a_mode2_fast: assert property ((mode == 2'b10 && st_reg.double_rate && tick_pre) |=> s_gap1)
    else $error("mode 2 double rate tick spacing wrong");
  a_mode0_slow: assert property ((mode == 2'b00 && !st_reg.multiproc_enable && tick_pre) |=> s_gap5)
    else $error("mode 0 divide by 12 spacing wrong");
  a_rx_enable_gate: assert property ((!st_reg.rx_enable && st_reg.rx_state == RX_IDLE) |=> st_reg.rx_state == RX_IDLE)
    else $error("reception started while disabled");
  a_ninth_zero_block: assert property ((stop_eval && mode[1] && st_reg.multiproc_enable && !st_reg.rx_shift[8] &&
    !st_reg.rx_done_flag) |=> !st_reg.rx_done_flag)
    else $error("receive done set on ninth bit zero");
  a_stop_bad_block: assert property ((stop_eval && mode == 2'b01 && st_reg.multiproc_enable && !rxd_in &&
    !st_reg.rx_done_flag) |=> !st_reg.rx_done_flag && st_reg.frame_error)
    else $error("mode 1 bad stop bit accepted");
  a_frame_error_sticky: assert property ((st_reg.frame_error && !(wr_go && st_reg.aw_addr == `ADDR_CTRL)) |=>
    st_reg.frame_error)
    else $error("frame error dropped without software");
  a_mask_zero_any: assert property ((stop_eval && mode[1] && st_reg.multiproc_enable && st_reg.rx_shift[8] &&
    st_reg.address_compare_mask == 8'h00) |=> st_reg.rx_done_flag)
    else $error("zero mask did not accept address");
  a_mask_mismatch: assert property ((stop_eval && mode[1] && st_reg.multiproc_enable && !st_reg.rx_done_flag &&
    (((st_reg.rx_shift[7:0] ^ st_reg.station_address) & st_reg.address_compare_mask) != 8'h00)) |=>
    !st_reg.rx_done_flag)
    else $error("mismatched address accepted");
  a_ninth_bit_sent: assert property ((st_reg.tx_state == TX_IDLE && fifo_out_valid && fifo_out_ready && mode[1]) |=>
    st_reg.tx_shift[9] == $past(st_reg.tx_ninth_bit))
    else $error("ninth bit not taken from control");
  a_tx_done_at_stop: assert property (($rose(st_reg.tx_done_flag) && mode != 2'b00 &&
    st_reg.tx_state == TX_SHIFT) |-> st_reg.txd)
    else $error("transmit done not at stop bit start");
  a_data_read: assert property ((arvalid && st_reg.arready && araddr == `ADDR_DATA) |=>
    st_reg.rvalid && st_reg.rdata == $past(st_reg.rx_buf))
    else $error("data buffer read not from receive register");
  a_stop_in_ninth: assert property ((stop_eval && mode == 2'b01 && !st_reg.multiproc_enable && !st_reg.rx_done_flag)
    |=> st_reg.rx_ninth_bit == $past(rxd_in))
    else $error("mode 1 stop bit not stored");
endmodule

//--- hdl/serial_port_consts.svh
/*
  Constants of the second serial port: register indices and byte addresses,
  control field positions, bus response codes and bit timing counts.
  Assumes inclusion by bare name from the bench and the design file.
*/
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define IDX_STATION_ADDR 10'h0aa
`define IDX_ADDR_MASK 10'h0ba
`define IDX_CTRL_STATUS 10'h0c0
`define IDX_DATA_BUF 10'h0c1
`define IDX_POWER_CTRL 10'h0c3
`define ADDR_STATION {`IDX_STATION_ADDR, 2'b00}
`define ADDR_MASK {`IDX_ADDR_MASK, 2'b00}
`define ADDR_CTRL {`IDX_CTRL_STATUS, 2'b00}
`define ADDR_DATA {`IDX_DATA_BUF, 2'b00}
`define ADDR_POWER {`IDX_POWER_CTRL, 2'b00}

// ****************************************
// Field positions
// ****************************************
`define CTL_MODE_LOW 7
`define CTL_MODE_HIGH 6
`define CTL_MULTIPROC 5
`define CTL_RX_ENABLE 4
`define CTL_TX_NINTH 3
`define CTL_RX_NINTH 2
`define CTL_TX_DONE 1
`define CTL_RX_DONE 0
`define PWR_FE_SELECT 0
`define PWR_DOUBLE_RATE 1

// ****************************************
// Bus answers and timing
// ****************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define M0_CLK_SLOW 12
`define M0_CLK_FAST 4
`define M2_CLK_SLOW 64
`define M2_CLK_FAST 32
`define OVERSAMPLE 16
`define FIFO_DEPTH 8
`define DATA_WIDTH 8

`endif

//--- hdl/serial_port_pkg.sv
/*
  Types of the second serial port: engine states and the register state record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package serial_port_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

  typedef struct packed {
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_en;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] address_compare_mask;
    logic [7:0] station_address;
    logic frame_error_select;
    logic double_rate;
    logic mode_low;
    logic mode_high_bit;
    logic multiproc_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
    logic frame_error;
    logic [7:0] rx_buf;
    logic txd;
    logic rxd_out;
    logic rxd_oe;
    logic [3:0] pre_cnt;
    tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_os;
    rx_state_t rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_bits;
    logic [3:0] rx_os;
  } port_state_t;

endpackage
